// [logic/fcms_pkg.sv]
// constants, modes and carrier types of the configuration mode sequencer
// assumes one 10 MHz core clock shared by every file that imports it
package fcms_pkg;

    // clock and timing
    localparam int CORE_CLK_HZ   = 10_000_000;
    localparam int LOAD_STALL_MS = 100;
    localparam int LOAD_STALL_CYC = LOAD_STALL_MS * (CORE_CLK_HZ / 1000);
    localparam int CFG_BYTES_DEF = 4096;
    localparam int INIT_CYC_DEF  = 16;

    // configuration stream
    localparam int BYTE_W    = 8;
    localparam int BIT_IDX_W = 3;
    localparam logic [BIT_IDX_W-1:0] BIT_IDX_LAST = 3'h7;

    // identification code layout
    localparam int ID_VER_W  = 4;
    localparam int ID_PART_W = 16;
    localparam int ID_MFR_W  = 11;
    localparam logic ID_LSB  = 1'b1;

    // scheme select pin codes
    localparam int MSEL_W = 3;
    localparam logic [MSEL_W-1:0] MSEL_CFG_MEM = 3'h0;
    localparam logic [MSEL_W-1:0] MSEL_SER     = 3'h1;
    localparam logic [MSEL_W-1:0] MSEL_FPP     = 3'h2;
    localparam logic [MSEL_W-1:0] MSEL_PAR_ASYNC = 3'h3;
    localparam logic [MSEL_W-1:0] MSEL_JTAG    = 3'h4;

    // pll counter chain layout and reset values
    localparam int PLL_MUL_W = 9;
    localparam int PLL_DIV_W = 9;
    localparam int PLL_DLY_W = 4;
    localparam logic [PLL_MUL_W-1:0] PLL_MUL_RST = 9'h001;
    localparam logic [PLL_DIV_W-1:0] PLL_DIV_RST = 9'h001;
    localparam logic [PLL_DLY_W-1:0] PLL_DLY_RST = 4'h0;

    typedef enum logic [2:0] {
        md_por, md_wait_ce, md_load, md_init, md_user, md_fault
    } fcms_mode_t;

    typedef enum logic [2:0] {
        scheme_cfg_mem, passive_serial_scheme, fast_passive_parallel_scheme,
        passive_parallel_async_scheme, jtag_scheme, scheme_none
    } fcms_scheme_t;

    typedef struct packed {
        logic              dclk;
        logic              wr_n;
        logic [BYTE_W-1:0] data;
    } fcms_cfg_pins_t;

    typedef struct packed {
        logic [PLL_MUL_W-1:0] mul;
        logic [PLL_DIV_W-1:0] div;
        logic [PLL_DLY_W-1:0] dly;
    } fcms_pll_cfg_t;

    typedef struct packed {
        logic user_mode;
        logic command_mode;
        logic io_oe;
        logic user_reset_n;
        logic done;
        logic error;
    } fcms_status_t;

endpackage

// [logic/fcms_pll_chain.sv]
// serial chain that rewrites the pll multiply, divide and delay counters
// assumes pin inputs are asynchronous and internal inputs are on core_clk
module fcms_pll_chain
    import fcms_pkg::*;
(
    // clock and reset
    input  wire logic          core_clk,
    input  wire logic          rst_b,
    // control
    input  wire logic          chain_en,
    input  wire logic          src_pins,
    // pin source
    input  wire logic          pin_clk,
    input  wire logic          pin_data,
    input  wire logic          pin_update,
    // internal logic source
    input  wire logic          int_shift,
    input  wire logic          int_data,
    input  wire logic          int_update,
    // counter settings
    output fcms_pll_cfg_t      pll_cfg,
    output logic               pll_updated
);
    localparam int CHAIN_W = $bits(fcms_pll_cfg_t);

    typedef struct packed {
        logic [2:0]         clk_s;
        logic [1:0]         dat_s;
        logic [2:0]         upd_s;
        logic [CHAIN_W-1:0] sh;
        fcms_pll_cfg_t      cfg;
        logic               updated;
    } fcms_pll_st_t;

    fcms_pll_st_t q;
    fcms_pll_st_t d;
    logic         shift_ev;
    logic         upd_ev;
    logic         bit_in;

    always_comb
    begin
        d = q;
        d.clk_s = {q.clk_s[1:0], pin_clk};
        d.dat_s = {q.dat_s[0], pin_data};
        d.upd_s = {q.upd_s[1:0], pin_update};
        d.updated = 1'b0;
        shift_ev = src_pins ? (q.clk_s[1] & ~q.clk_s[2]) : int_shift;
        upd_ev   = src_pins ? (q.upd_s[1] & ~q.upd_s[2]) : int_update;
        bit_in   = src_pins ? q.dat_s[1] : int_data;
        // only live in user mode so the rest of the device is never disturbed
        if (chain_en)
        begin
            if (shift_ev)
            begin
                d.sh = {q.sh[CHAIN_W-2:0], bit_in};
            end
            if (upd_ev)
            begin
                d.cfg = q.sh;
                d.updated = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            q <= '0;
            q.cfg <= '{mul: PLL_MUL_RST, div: PLL_DIV_RST, dly: PLL_DLY_RST};
        end
        else
        begin
            q <= d;
        end
    end

    assign pll_cfg     = q.cfg;
    assign pll_updated = q.updated;

    chk_pll_load: assert property (@(posedge core_clk) disable iff (!rst_b)
        (chain_en && upd_ev) |=> (pll_cfg == $past(q.sh)) && pll_updated)
        else $error("pll counters not loaded from chain");

    chk_pll_idle: assert property (@(posedge core_clk) disable iff (!rst_b)
        !chain_en |=> $stable(pll_cfg) && !pll_updated)
        else $error("pll counters changed outside user mode");

endmodule

// [logic/fcms_top.sv]
// configuration mode sequencer: command mode load, init, user mode, pll chain
// assumes config pins are asynchronous; jtag inputs come from core_clk logic
// Function
// - identification code always ends in one
// - every power-up needs a full load
// - user pins high impedance until configured
// - init resets registers, enables pins, then runs
// - exactly one of command or user mode
// - request pin forces reload from user mode
// - five load schemes, source follows chosen one
// - load starts only on chain enable; pass on
// - byte-wide parallel path, one byte per strobe
// - processor writes bytes to one location
// - pll counters reloaded through serial chain
// - pll reload leaves user mode running
module fcms_top
    import fcms_pkg::*;
#(
    parameter int                   CFG_BYTES  = CFG_BYTES_DEF,
    parameter int                   INIT_CYC   = INIT_CYC_DEF,
    parameter int                   STALL_CYC  = LOAD_STALL_CYC,
    // identity values are arbitrary
    parameter logic [ID_VER_W-1:0]  ID_VERSION = 4'h1,
    parameter logic [ID_PART_W-1:0] ID_PART    = 16'h5A5A,
    parameter logic [ID_MFR_W-1:0]  ID_MFR     = 11'h2A5
)
(
    // clock and reset
    input  wire logic          core_clk,
    input  wire logic          rst_b,
    // configuration pins
    input  wire logic          config_req_n,
    input  wire logic          chain_enable_in_n,
    input  wire logic [MSEL_W-1:0] scheme_sel,
    input  fcms_cfg_pins_t     cfg_pins,
    // boundary-scan side
    input  wire logic          jtag_cfg_bit,
    input  wire logic          jtag_cfg_valid,
    output logic [31:0]        jtag_idcode,
    // loaded configuration bytes
    output logic [BYTE_W-1:0]  cfg_byte,
    output logic               cfg_byte_valid,
    // chain and status
    output logic               chain_enable_out_n,
    output fcms_status_t       status,
    // pll counter chain
    input  wire logic          pll_src_pins,
    input  wire logic          pll_pin_clk,
    input  wire logic          pll_pin_data,
    input  wire logic          pll_pin_update,
    input  wire logic          pll_int_shift,
    input  wire logic          pll_int_data,
    input  wire logic          pll_int_update,
    output fcms_pll_cfg_t      pll_cfg,
    output logic               pll_updated
);
    localparam int CNT_W   = $clog2(CFG_BYTES + 1);
    localparam int STALL_W = $clog2(STALL_CYC + 1);
    localparam int INIT_W  = $clog2(INIT_CYC + 1);
    localparam logic [CNT_W-1:0]   BYTE_LAST  = CNT_W'(CFG_BYTES - 1);
    localparam logic [STALL_W-1:0] STALL_LAST = STALL_W'(STALL_CYC - 1);
    localparam logic [INIT_W-1:0]  INIT_LAST  = INIT_W'(INIT_CYC - 1);

    if (CFG_BYTES < 1 || INIT_CYC < 1 || STALL_CYC < 2)
    begin : g_bad_param
        $error("fcms_top: counts must be positive");
    end

    typedef struct packed {
        fcms_mode_t         mode;
        fcms_scheme_t       scheme;
        logic [1:0]         req_s;
        logic [1:0]         ce_s;
        logic [2:0]         dclk_s;
        logic [2:0]         wr_s;
        logic [BYTE_W-1:0]  dat_s1;
        logic [BYTE_W-1:0]  dat_s2;
        logic [MSEL_W-1:0]  sel_s1;
        logic [MSEL_W-1:0]  sel_s2;
        logic [BYTE_W-1:0]  shreg;
        logic [BIT_IDX_W-1:0] bit_idx;
        logic [CNT_W-1:0]   byte_cnt;
        logic [STALL_W-1:0] stall_cnt;
        logic [INIT_W-1:0]  init_cnt;
        logic [BYTE_W-1:0]  byte_q;
        logic               byte_vld;
        logic               ceo_n;
        logic               done;
        logic               err;
    } fcms_st_t;

    // scheme pins map onto the five load schemes; anything else is refused
    function automatic fcms_scheme_t fcms_decode(input logic [MSEL_W-1:0] sel);
        fcms_scheme_t s;
        case (sel)
            MSEL_CFG_MEM: s = scheme_cfg_mem;
            MSEL_SER:     s = passive_serial_scheme;
            MSEL_FPP:     s = fast_passive_parallel_scheme;
            MSEL_PAR_ASYNC: s = passive_parallel_async_scheme;
            MSEL_JTAG:    s = jtag_scheme;
            default:      s = scheme_none;
        endcase
        return s;
    endfunction

    // which strobe carries data for a scheme: {byte event, bit event}
    function automatic logic [1:0] fcms_event(input fcms_scheme_t s, input logic dclk_rise,
                                              input logic wr_rise, input logic jtag_v);
        logic [1:0] e;
        case (s)
            scheme_cfg_mem:                e = {1'b0, dclk_rise};
            passive_serial_scheme:         e = {1'b0, dclk_rise};
            fast_passive_parallel_scheme:  e = {dclk_rise, 1'b0};
            passive_parallel_async_scheme: e = {wr_rise, 1'b0};
            jtag_scheme:                   e = {1'b0, jtag_v};
            default:                       e = 2'h0;
        endcase
        return e;
    endfunction

    fcms_st_t          q;
    fcms_st_t          d;
    logic              req_high;
    logic              dclk_rise;
    logic              wr_rise;
    logic [1:0]        ev;
    logic              bit_in;
    logic              got_byte;
    logic [BYTE_W-1:0] new_byte;
    logic              in_user;

    assign req_high  = q.req_s[1];
    assign dclk_rise = q.dclk_s[1] & ~q.dclk_s[2];
    // the processor's write lands when its strobe is released
    assign wr_rise   = q.wr_s[1] & ~q.wr_s[2];

    always_comb
    begin
        d = q;
        ev = fcms_event(q.scheme, dclk_rise, wr_rise, jtag_cfg_valid);
        bit_in = (q.scheme == jtag_scheme) ? jtag_cfg_bit : q.dat_s2[0];
        got_byte = 1'b0;
        new_byte = q.dat_s2;
        d.req_s  = {q.req_s[0], config_req_n};
        d.ce_s   = {q.ce_s[0], chain_enable_in_n};
        d.dclk_s = {q.dclk_s[1:0], cfg_pins.dclk};
        d.wr_s   = {q.wr_s[1:0], cfg_pins.wr_n};
        d.dat_s1 = cfg_pins.data;
        d.dat_s2 = q.dat_s1;
        d.sel_s1 = scheme_sel;
        d.sel_s2 = q.sel_s1;
        d.byte_vld = 1'b0;
        case (q.mode)
            md_por:
            begin
                // storage is volatile: every start goes through a load
                if (req_high)
                begin
                    d.mode = md_wait_ce;
                end
            end
            md_wait_ce:
            begin
                // a chained device waits for its predecessor
                if (!q.ce_s[1])
                begin
                    d.scheme    = fcms_decode(q.sel_s2);
                    d.bit_idx   = '0;
                    d.byte_cnt  = '0;
                    d.stall_cnt = '0;
                    d.mode      = (fcms_decode(q.sel_s2) == scheme_none) ? md_fault : md_load;
                    d.err       = (fcms_decode(q.sel_s2) == scheme_none);
                end
            end
            md_load:
            begin
                if (ev[1])
                begin
                    got_byte = 1'b1;
                end
                else if (ev[0])
                begin
                    d.shreg   = {bit_in, q.shreg[BYTE_W-1:1]};
                    d.bit_idx = q.bit_idx + 1'b1;
                    if (q.bit_idx == BIT_IDX_LAST)
                    begin
                        got_byte = 1'b1;
                        new_byte = {bit_in, q.shreg[BYTE_W-1:1]};
                    end
                end
                if (got_byte)
                begin
                    d.byte_q   = new_byte;
                    d.byte_vld = 1'b1;
                    d.byte_cnt = q.byte_cnt + 1'b1;
                    if (q.byte_cnt == BYTE_LAST)
                    begin
                        d.mode     = md_init;
                        d.init_cnt = '0;
                    end
                end
                // a source that goes quiet mid-load leaves the device unconfigured
                if (ev != 2'h0)
                begin
                    d.stall_cnt = '0;
                end
                else if (q.stall_cnt == STALL_LAST)
                begin
                    d.mode = md_fault;
                    d.err  = 1'b1;
                end
                else
                begin
                    d.stall_cnt = q.stall_cnt + 1'b1;
                end
            end
            md_init:
            begin
                // registers held in reset while pins come alive
                d.init_cnt = q.init_cnt + 1'b1;
                if (q.init_cnt == INIT_LAST)
                begin
                    d.mode  = md_user;
                    d.done  = 1'b1;
                    d.ceo_n = 1'b0;
                end
            end
            md_user:
            begin
                d.mode = md_user;
            end
            md_fault:
            begin
                d.mode = md_fault;
            end
            default:
            begin
                d.mode = md_por;
            end
        endcase
        // the request pin wins from every state and restarts the load
        if (!req_high)
        begin
            d.mode  = md_por;
            d.done  = 1'b0;
            d.err   = 1'b0;
            d.ceo_n = 1'b1;
            d.byte_vld = 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            q <= '0;
            q.ceo_n <= 1'b1;
            // idle strobe level, so leaving reset never fakes a write edge
            q.wr_s  <= '1;
        end
        else
        begin
            q <= d;
        end
    end

    assign in_user = (q.mode == md_user);

    // outputs
    assign jtag_idcode = {ID_VERSION, ID_PART, ID_MFR, ID_LSB};
    assign cfg_byte    = q.byte_q;
    assign cfg_byte_valid = q.byte_vld;
    assign chain_enable_out_n = q.ceo_n;
    assign status.user_mode    = in_user;
    assign status.command_mode = !in_user;
    // pins stay released through load and fault; enabled from init onward
    assign status.io_oe        = in_user || (q.mode == md_init);
    assign status.user_reset_n = in_user;
    assign status.done         = q.done;
    assign status.error        = q.err;

    fcms_pll_chain u_pll_chain
    (
        .core_clk    (core_clk),
        .rst_b       (rst_b),
        .chain_en    (in_user),
        .src_pins    (pll_src_pins),
        .pin_clk     (pll_pin_clk),
        .pin_data    (pll_pin_data),
        .pin_update  (pll_pin_update),
        .int_shift   (pll_int_shift),
        .int_data    (pll_int_data),
        .int_update  (pll_int_update),
        .pll_cfg     (pll_cfg),
        .pll_updated (pll_updated)
    );

    chk_idcode_lsb: assert property (@(posedge core_clk) disable iff (!rst_b)
        jtag_idcode[0] == 1'b1)
        else $error("identification code lsb not one");

    chk_user_after_init: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(status.user_mode) |-> $past(q.mode) == md_init && $past(q.byte_cnt) == CNT_W'(CFG_BYTES))
        else $error("user mode entered without full load and init");

    chk_pins_hiz: assert property (@(posedge core_clk) disable iff (!rst_b)
        (q.mode inside {md_por, md_wait_ce, md_load, md_fault}) |-> !status.io_oe)
        else $error("user pins driven before configuration ends");

    chk_init_exit: assert property (@(posedge core_clk) disable iff (!rst_b)
        (q.mode == md_init && q.init_cnt == INIT_LAST && req_high)
        |=> status.user_mode && status.user_reset_n && status.io_oe)
        else $error("init did not hand over to user mode");

    chk_one_mode: assert property (@(posedge core_clk) disable iff (!rst_b)
        status.user_mode ^ status.command_mode)
        else $error("command and user mode not exclusive");

    chk_reconfig_req: assert property (@(posedge core_clk) disable iff (!rst_b)
        (status.user_mode && !req_high) |=> q.mode == md_por ##1 !status.user_mode)
        else $error("reconfiguration request ignored");

    chk_ce_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
        (q.mode == md_wait_ce && q.ce_s[1]) |=> q.mode != md_load)
        else $error("load started without chain enable");

    chk_ceo_done: assert property (@(posedge core_clk) disable iff (!rst_b)
        !chain_enable_out_n |-> status.done && status.user_mode)
        else $error("chain enable passed on before done");

    chk_scheme_valid: assert property (@(posedge core_clk) disable iff (!rst_b)
        q.mode == md_load |-> q.scheme != scheme_none)
        else $error("load running with no scheme");

    chk_par_byte: assert property (@(posedge core_clk) disable iff (!rst_b)
        (q.mode == md_load && req_high && q.scheme == passive_parallel_async_scheme && wr_rise)
        |=> cfg_byte_valid && cfg_byte == $past(q.dat_s2))
        else $error("parallel write not taken as byte");

    chk_stall_fault: assert property (@(posedge core_clk) disable iff (!rst_b)
        (q.mode == md_load && req_high && ev == 2'h0 && q.stall_cnt == STALL_LAST)
        |=> q.mode == md_fault && status.error && !status.io_oe)
        else $error("stalled load did not fault");

    chk_pll_user: assert property (@(posedge core_clk) disable iff (!rst_b)
        (status.user_mode && req_high && pll_updated) |=> status.user_mode)
        else $error("pll reload disturbed user mode");

endmodule

// [tb/fcms_cfg_source.sv]
// configuration source model: data pins, strobes and boundary-scan bits
// assumes core_clk is the device clock; pin strobes hold 3 cycles a phase
module fcms_cfg_source
    import fcms_pkg::*;
(
    // clock
    input  wire logic          core_clk,
    // toward the device
    output fcms_cfg_pins_t     cfg_pins,
    output logic               jtag_cfg_bit,
    output logic               jtag_cfg_valid
);
    timeunit 1ns;
    timeprecision 1ns;

    // two sync flops in the device need two cycles a phase; 3 leaves margin
    localparam int PH = 3;

    initial
    begin
        cfg_pins       = '{dclk: 1'b0, wr_n: 1'b1, data: 8'h00};
        jtag_cfg_bit   = 1'b0;
        jtag_cfg_valid = 1'b0;
    end

    task automatic send(input logic [MSEL_W-1:0] sch, input logic [BYTE_W-1:0] b);
        int n;
        n = (sch == MSEL_FPP || sch == MSEL_PAR_ASYNC) ? 1 : BYTE_W;
        for (int i = 0; i < n; i++)
        begin
            @(posedge core_clk);
            if (sch == MSEL_JTAG)
            begin
                jtag_cfg_bit   <= b[i]; // lsb first, one bit a valid cycle
                jtag_cfg_valid <= 1'b1;
            end
            else
            begin
                cfg_pins.data <= (n == 1) ? b : {7'h00, b[i]}; // byte wide or serial on bit 0
                cfg_pins.wr_n <= (sch != MSEL_PAR_ASYNC);
                cfg_pins.dclk <= 1'b0;
                repeat (PH) @(posedge core_clk);
                cfg_pins.dclk <= (sch != MSEL_PAR_ASYNC); // data taken on the rising strobe
                cfg_pins.wr_n <= 1'b1;
                repeat (PH) @(posedge core_clk);
                cfg_pins.dclk <= 1'b0;
                cfg_pins.data <= ~cfg_pins.data; // released data must not look still valid
            end
        end
        if (sch == MSEL_JTAG)
        begin
            @(posedge core_clk);
            jtag_cfg_valid <= 1'b0;
            jtag_cfg_bit   <= ~jtag_cfg_bit;
        end
    endtask
endmodule

// [tb/fcms_top_bench.sv]
// self-checking bench of the configuration mode sequencer
// assumes one 10 MHz clock; counts shortened through the top parameters
`define CHK(what, exp, got) \
    begin num_checks++; if ((got) !== (exp)) begin err_total++; \
    $display("[FAIL] %s expected %0h seen %0h", what, exp, got); end end

module fcms_top_bench
    import fcms_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int N_BYTES = 8;
    localparam int N_INIT  = 4;
    localparam int N_STALL = 64;
    localparam int B_ERR   = 0;
    localparam int B_IO    = 3;
    localparam int B_USER  = 5;
    localparam int B_PLL   = 6;

    logic                  core_clk;
    logic                  rst_b;
    logic                  config_req_n;
    logic                  chain_enable_in_n;
    logic [MSEL_W-1:0]     scheme_sel;
    fcms_cfg_pins_t        cfg_pins;
    logic                  jtag_cfg_bit;
    logic                  jtag_cfg_valid;
    logic [31:0]           jtag_idcode;
    logic [BYTE_W-1:0]     cfg_byte;
    logic                  cfg_byte_valid;
    logic                  chain_enable_out_n;
    fcms_status_t          status;
    logic                  pll_src_pins;
    logic                  pll_pin_clk;
    logic                  pll_pin_data;
    logic                  pll_pin_update;
    logic                  pll_int_shift;
    logic                  pll_int_data;
    logic                  pll_int_update;
    fcms_pll_cfg_t         pll_cfg;
    logic                  pll_updated;
    logic [6:0]            watch;
    logic [BYTE_W-1:0]     exp_q[$];
    logic [8:0]            exp_b;
    int                    err_total = 0;
    int                    num_checks = 0;

    assign watch = {pll_updated, status};

    fcms_top #(.CFG_BYTES(N_BYTES), .INIT_CYC(N_INIT), .STALL_CYC(N_STALL)) i_fcms_top (
        .core_clk(core_clk), .rst_b(rst_b), .config_req_n(config_req_n),
        .chain_enable_in_n(chain_enable_in_n), .scheme_sel(scheme_sel), .cfg_pins(cfg_pins),
        .jtag_cfg_bit(jtag_cfg_bit), .jtag_cfg_valid(jtag_cfg_valid), .jtag_idcode(jtag_idcode),
        .cfg_byte(cfg_byte), .cfg_byte_valid(cfg_byte_valid), .chain_enable_out_n(chain_enable_out_n),
        .status(status), .pll_src_pins(pll_src_pins), .pll_pin_clk(pll_pin_clk),
        .pll_pin_data(pll_pin_data), .pll_pin_update(pll_pin_update), .pll_int_shift(pll_int_shift),
        .pll_int_data(pll_int_data), .pll_int_update(pll_int_update), .pll_cfg(pll_cfg),
        .pll_updated(pll_updated));

    fcms_cfg_source i_fcms_cfg_source (.core_clk(core_clk), .cfg_pins(cfg_pins),
        .jtag_cfg_bit(jtag_cfg_bit), .jtag_cfg_valid(jtag_cfg_valid));

    always #50 core_clk = ~core_clk;

    // byte model: every assembled byte must match the queue in order
    always @(posedge core_clk)
    begin
        if (rst_b === 1'b1)
        begin
            `CHK("one mode", 1'b1, status.user_mode ^ status.command_mode)
            if (cfg_byte_valid === 1'b1)
            begin
                exp_b = (exp_q.size() > 0) ? {1'b0, exp_q.pop_front()} : 9'h1FF;
                `CHK("loaded byte", exp_b, {1'b0, cfg_byte})
            end
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic wait_bit(input int idx, input int lim);
        for (int i = 0; i < lim; i++)
        begin
            @(posedge core_clk);
            if (watch[idx] === 1'b1)
                break;
        end
        `CHK("awaited flag", 1'b1, watch[idx])
    endtask

    task automatic reload(input logic [MSEL_W-1:0] sch);
        @(posedge core_clk);
        config_req_n      <= 1'b0;
        chain_enable_in_n <= 1'b1;
        scheme_sel        <= sch;
        cyc(4);
        `CHK("request drops user mode", 1'b0, status.user_mode)
        `CHK("request clears done", 1'b0, status.done)
        `CHK("chain out released", 1'b1, chain_enable_out_n)
        config_req_n <= 1'b1;
        i_fcms_cfg_source.send(sch, 8'h3C);
        `CHK("idle without chain enable", 1'b0, status.error | status.io_oe)
        chain_enable_in_n <= 1'b0;
        // load opens only after the synced chain enable; earlier bits would be lost
        cyc(4);
    endtask

    task automatic load(input logic [MSEL_W-1:0] sch, input int n);
        logic [BYTE_W-1:0] b;
        for (int k = 0; k < n; k++)
        begin
            `CHK("pins high-z while loading", 1'b0, status.io_oe)
            `CHK("no user mode mid-load", 1'b0, status.user_mode)
            b = BYTE_W'($urandom);
            exp_q.push_back(b);
            i_fcms_cfg_source.send(sch, b);
        end
    endtask

    task automatic to_user();
        wait_bit(B_IO, 40);
        `CHK("init holds registers in reset", 1'b0, status.user_reset_n)
        `CHK("init is command mode", 1'b1, status.command_mode)
        wait_bit(B_USER, N_INIT + 8);
        cyc(2);
        `CHK("user pins enabled", 1'b1, status.io_oe & status.user_reset_n & status.done)
        `CHK("chain out passes on", 1'b0, chain_enable_out_n)
        `CHK("all bytes taken", 0, exp_q.size())
    endtask

    task automatic pll_load(input logic pins);
        fcms_pll_cfg_t v;
        v = fcms_pll_cfg_t'($urandom);
        pll_src_pins <= pins;
        for (int i = $bits(v) - 1; i >= 0; i--)
        begin
            @(posedge core_clk);
            pll_int_data  <= v[i]; // msb first into the multiply field
            pll_pin_data  <= v[i];
            pll_int_shift <= ~pins;
            pll_pin_clk   <= 1'b0;
            if (pins)
            begin
                cyc(3);
                pll_pin_clk <= 1'b1;
                cyc(2);
            end
        end
        @(posedge core_clk);
        pll_int_shift  <= 1'b0;
        pll_pin_clk    <= 1'b0;
        pll_int_update <= ~pins;
        pll_pin_update <= pins;
        @(posedge core_clk);
        pll_int_update <= 1'b0;
        wait_bit(B_PLL, 10);
        `CHK("pll settings", v, pll_cfg)
        `CHK("user mode kept", 1'b1, status.user_mode & status.io_oe)
        pll_pin_update <= 1'b0;
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // watchdog: the full sequence needs well under 10000 cycles
    initial
    begin
        cyc(30000);
        err_total++;
        end_of_test();
    end

    initial
    begin
        core_clk = 1'b0;
        rst_b = 1'b0;
        config_req_n = 1'b1;
        chain_enable_in_n = 1'b1;
        scheme_sel = MSEL_FPP;
        {pll_src_pins, pll_pin_clk, pll_pin_data, pll_pin_update} = 4'h0;
        {pll_int_shift, pll_int_data, pll_int_update} = 3'h0;
        void'($urandom(38480));
        cyc(8);
        rst_b <= 1'b1;
        `CHK("reset in command mode", 1'b1, status.command_mode & ~status.io_oe)
        `CHK("reset chain out", 1'b1, chain_enable_out_n)
        `CHK("pll reset", {PLL_MUL_RST, PLL_DIV_RST, PLL_DLY_RST}, pll_cfg)
        `CHK("id code low bit", 1'b1, jtag_idcode[0])
        for (int s = 0; s < 5; s++)
        begin
            reload(MSEL_W'(s)); // every scheme code once
            load(MSEL_W'(s), N_BYTES);
            to_user();
        end
        pll_load(1'b0);
        pll_load(1'b1);
        reload(MSEL_FPP);
        load(MSEL_FPP, 3);
        wait_bit(B_ERR, N_STALL + 40);
        `CHK("aborted load stays off", 1'b1, status.command_mode & ~status.io_oe)
        reload(3'h5);
        wait_bit(B_ERR, 20);
        `CHK("bad scheme stays off", 1'b0, status.io_oe | status.user_mode)
        reload(MSEL_PAR_ASYNC);
        load(MSEL_PAR_ASYNC, N_BYTES);
        to_user();
        end_of_test();
    end
endmodule
